/* pkg/synlk_pkg.sv */
package synlk_pkg;

  // front-panel mode switch
  typedef enum logic [1:0] {
    SYNLK_MODE_USB,
    SYNLK_MODE_LSB,
    SYNLK_MODE_AM,
    SYNLK_MODE_SPARE
  } synlk_mode_e;

  // main loop: dual-modulus prescaler, swallow and main divider
  localparam logic [6:0] PRESC_HI = 7'h65;
  localparam logic [6:0] PRESC_LO = 7'h64;
  localparam int PRESC_W = 7;
  localparam int SWALLOW_W = 7;
  localparam int MAIN_W = 13;
  // main count for 0 Hz on the dial: first IF over the 10 kHz step
  localparam logic [12:0] MAIN_BASE = 13'h0dd4;

  // second loop: fixed prescaler and mode-selected divider
  localparam logic [4:0] AUX_PRESC = 5'h14;
  localparam logic [6:0] AUX_DIV_USB = 7'h55;
  localparam logic [6:0] AUX_DIV_LSB = 7'h5c;
  localparam int AUX_TARGET_LSB_KHZ = 36800;
  localparam int AUX_TARGET_USB_KHZ = 34000;

  // reference chain after the divide-by-four: 200k,100k,20k,1k,500,100,10 Hz
  localparam int REF_STAGES = 7;
  localparam logic [4:0] REF_MOD [REF_STAGES] = '{5'h07, 5'h02, 5'h05, 5'h14,
                                                  5'h02, 5'h05, 5'h0a};
  localparam int REF_IDX_100KHZ = 1;
  localparam int REF_IDX_20KHZ = 2;
  localparam int REF_IDX_1KHZ = 3;
  localparam int REF_IDX_500HZ = 4;
  localparam int REF_IDX_100HZ = 5;
  localparam int REF_IDX_10HZ = 6;

  // coincidence window of the lock detectors, in system clocks
  localparam int LOCK_WIN_CYC = 4;
  localparam int LOCK_WIN_W = 4;

  // register map
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_COUNT = 4'h8;
  localparam logic [3:0] REG_UNLK_CNT = 4'hc;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam int CTRL_TONE_EN = 0;
  localparam int CTRL_FORCE_MUTE = 1;
  localparam int COUNT_M_LSB = 16;

endpackage

/* src/synlk_sync.sv */
`timescale 1ns/1ps
module synlk_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // asynchronous pins
  input wire logic [W-1:0] i_pin,
  // settled level and its rising edge
  output logic [W-1:0] o_level,
  output logic [W-1:0] o_rise
);

  logic [W-1:0] ff1_r;
  logic [W-1:0] ff2_r;
  logic [W-1:0] ff3_r;
  logic [W-1:0] lvl_r;
  logic [W-1:0] rise_r;
  wire logic [W-1:0] agree = ~(ff2_r ^ ff3_r);
  // a bit only moves once the second and third stages agree
  wire logic [W-1:0] lvl_nxt = (ff2_r & agree) | (lvl_r & ~agree);

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      ff1_r <= '0;
      ff2_r <= '0;
      ff3_r <= '0;
      lvl_r <= '0;
      rise_r <= '0;
    end
    else
    begin
      ff1_r <= i_pin;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
      lvl_r <= lvl_nxt;
      rise_r <= lvl_nxt & ~lvl_r;
    end
  end

  assign o_level = lvl_r;
  assign o_rise = rise_r;

endmodule

/* src/synlk_div.sv */
`timescale 1ns/1ps
module synlk_div #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // count input and modulus
  input wire logic i_tick,
  input wire logic [W-1:0] i_mod,
  // terminal pulse and divided square wave
  output logic o_tick,
  output logic o_wave
);

  logic [W-1:0] cnt_r;
  logic wave_r;
  // a modulus lowered mid-count wraps at once rather than running to overflow
  wire logic wrap = i_tick && (cnt_r >= i_mod - 1'b1);
  wire logic [W-1:0] cnt_nxt = !i_tick ? cnt_r : (wrap ? '0 : cnt_r + 1'b1);

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      cnt_r <= '0;
      wave_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      wave_r <= (cnt_nxt < (i_mod >> 1));
    end
  end

  assign o_tick = wrap;
  assign o_wave = wave_r;

endmodule

/* src/synlk_top.sv */
// Our own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module synlk_top #(
  parameter int LOCK_WIN = synlk_pkg::LOCK_WIN_CYC
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // oscillators
  input wire logic i_reference_oscillator,
  input wire logic i_main_vco,
  input wire logic i_aux_vco,
  // front panel
  input wire logic [3:0] i_sw_100hz,
  input wire logic [3:0] i_sw_1khz,
  input wire logic [3:0] i_sw_10khz,
  input wire logic [3:0] i_sw_100khz,
  input wire logic [3:0] i_sw_1mhz,
  input wire logic [1:0] i_mode,
  // transceiver outputs
  output logic o_clk14_i,
  output logic o_clk14_q,
  output logic o_ref_100khz,
  output logic o_ref_1khz,
  output logic o_tone,
  output logic o_mute,
  // comparator feeds and lock flags
  output logic o_main_fb,
  output logic o_main_ref,
  output logic o_aux_fb,
  output logic o_aux_ref,
  output logic o_main_unlock,
  output logic o_aux_unlock
);

  function automatic logic [6:0] bcd2(input logic [3:0] hi, input logic [3:0] lo);
    bcd2 = {3'h0, hi} * 7'd10 + {3'h0, lo};
  endfunction

  function automatic logic [1:0] gray_next(input logic [1:0] g);
    gray_next = {g[0], ~g[1]};
  endfunction

  // pin synchronisers
  logic [2:0] osc_lvl;
  logic [2:0] osc_rise;
  logic [21:0] pan_lvl;

  synlk_sync #(.W(3)) u_osc_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_pin({i_aux_vco, i_main_vco, i_reference_oscillator}),
    .o_level(osc_lvl),
    .o_rise(osc_rise)
  );

  synlk_sync #(.W(22)) u_pan_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_pin({i_mode, i_sw_1mhz, i_sw_100khz, i_sw_10khz, i_sw_1khz, i_sw_100hz}),
    .o_level(pan_lvl),
    .o_rise()
  );

  wire logic ref_tick = osc_rise[0];
  wire logic vco_tick = osc_rise[1];
  wire logic aux_vco_tick = osc_rise[2];
  wire synlk_pkg::synlk_mode_e mode = synlk_pkg::synlk_mode_e'(pan_lvl[21:20]);
  wire logic mode_lsb = (mode == synlk_pkg::SYNLK_MODE_LSB);

  // division counts from the panel digits
  wire logic [6:0] p_val = bcd2(pan_lvl[7:4], pan_lvl[3:0]);
  wire logic [12:0] m_val = synlk_pkg::MAIN_BASE + {9'h0, pan_lvl[19:16]} * 13'd100
                            + {6'h0, bcd2(pan_lvl[15:12], pan_lvl[11:8])};

  // reference chain
  logic [1:0] quad_r;
  logic [synlk_pkg::REF_STAGES:0] stage_tick;
  logic [synlk_pkg::REF_STAGES-1:0] stage_wave;

  // gray count gives two outputs a quarter period apart
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      quad_r <= 2'h0;
    else if (ref_tick)
      quad_r <= gray_next(quad_r);
  end

  assign stage_tick[0] = ref_tick && (quad_r == 2'h2);

  // stage 0 is the decade truncated to seven
  for (genvar s = 0; s < synlk_pkg::REF_STAGES; s++)
  begin : g_ref
    synlk_div #(.W(5)) u_stage (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_tick(stage_tick[s]),
      .i_mod(synlk_pkg::REF_MOD[s]),
      .o_tick(stage_tick[s+1]),
      .o_wave(stage_wave[s])
    );
  end

  wire logic ref100_tick = stage_tick[synlk_pkg::REF_IDX_100HZ+1];
  wire logic ref20k_tick = stage_tick[synlk_pkg::REF_IDX_20KHZ+1];

  // main loop
  logic [synlk_pkg::SWALLOW_W-1:0] sw_cnt_r;
  logic load_pend_r;
  logic pre_tick;
  logic main_tick;
  logic main_wave;
  wire logic sw_zero = (sw_cnt_r == '0);
  wire logic [6:0] pre_mod = sw_zero ? synlk_pkg::PRESC_LO : synlk_pkg::PRESC_HI;
  wire logic sw_load = main_tick || load_pend_r;
  wire logic [6:0] sw_cnt_nxt = sw_load ? p_val :
                                (pre_tick && !sw_zero) ? sw_cnt_r - 1'b1 : sw_cnt_r;

  synlk_div #(.W(synlk_pkg::PRESC_W)) u_main_pre (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_tick(vco_tick),
    .i_mod(pre_mod),
    .o_tick(pre_tick),
    .o_wave()
  );

  // wraps after m_val prescaler pulses: p at 101 then the rest at 100
  synlk_div #(.W(synlk_pkg::MAIN_W)) u_main_div (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_tick(pre_tick),
    .i_mod(m_val),
    .o_tick(main_tick),
    .o_wave(main_wave)
  );

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      sw_cnt_r <= '0;
      load_pend_r <= 1'b1;
    end
    else
    begin
      sw_cnt_r <= sw_cnt_nxt;
      load_pend_r <= 1'b0;
    end
  end

  // second loop
  logic aux_pre_tick;
  logic aux_tick;
  logic aux_wave;
  wire logic [6:0] aux_mod = mode_lsb ? synlk_pkg::AUX_DIV_LSB : synlk_pkg::AUX_DIV_USB;

  synlk_div #(.W(5)) u_aux_pre (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_tick(aux_vco_tick),
    .i_mod(synlk_pkg::AUX_PRESC),
    .o_tick(aux_pre_tick),
    .o_wave()
  );

  synlk_div #(.W(7)) u_aux_div (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_tick(aux_pre_tick),
    .i_mod(aux_mod),
    .o_tick(aux_tick),
    .o_wave(aux_wave)
  );

  // lock detectors: index 0 main loop, 1 second loop
  wire logic [1:0] ld_ref = {ref20k_tick, ref100_tick};
  wire logic [1:0] ld_fb = {aux_tick, main_tick};
  localparam int LOCK_WIN_W = synlk_pkg::LOCK_WIN_W;
  logic [1:0] unlock_r;

  for (genvar l = 0; l < 2; l++)
  begin : g_lock
    logic [synlk_pkg::LOCK_WIN_W-1:0] rwin_r;
    logic [synlk_pkg::LOCK_WIN_W-1:0] fwin_r;
    // a match is two edges together or one inside the other's window
    wire logic match = (ld_ref[l] && (ld_fb[l] || fwin_r != '0))
                       || (ld_fb[l] && rwin_r != '0);
    wire logic miss = (!match) && ((rwin_r == 4'h1 && !ld_fb[l])
                                   || (fwin_r == 4'h1 && !ld_ref[l]));
    wire logic open_r = ld_ref[l] && !match;
    wire logic open_f = ld_fb[l] && !match;

    always_ff @(posedge i_sys_clk)
    begin
      if (i_rst)
      begin
        rwin_r <= '0;
        fwin_r <= '0;
        unlock_r[l] <= 1'b1;
      end
      else
      begin
        rwin_r <= match ? '0 : open_r ? LOCK_WIN_W'(LOCK_WIN)
                  : (rwin_r != '0) ? rwin_r - 1'b1 : rwin_r;
        fwin_r <= match ? '0 : open_f ? LOCK_WIN_W'(LOCK_WIN)
                  : (fwin_r != '0) ? fwin_r - 1'b1 : fwin_r;
        unlock_r[l] <= match ? 1'b0 : miss ? 1'b1 : unlock_r[l];
      end
    end
  end

  // registers
  logic [1:0] ctrl_r;
  logic [15:0] unlk_cnt_r;
  logic any_unlock_d_r;
  wire logic any_unlock = |unlock_r;
  wire logic mute = any_unlock || ctrl_r[synlk_pkg::CTRL_FORCE_MUTE];
  wire logic tone = any_unlock && ctrl_r[synlk_pkg::CTRL_TONE_EN]
                    && stage_wave[synlk_pkg::REF_IDX_500HZ]
                    && stage_wave[synlk_pkg::REF_IDX_10HZ];
  wire logic unlock_evt = any_unlock && !any_unlock_d_r;

  // ahb-lite: zero wait states, always okay
  logic dp_wr_r;
  logic [3:0] dp_addr_r;
  logic [31:0] hrdata_r;
  wire logic ap_take = i_hsel && i_htrans[1] && i_hready;
  wire logic [3:0] ap_addr = i_haddr[3:0];
  wire logic ap_hit = (i_haddr[31:4] == '0) && (i_haddr[1:0] == 2'h0);
  wire logic wr_ctrl = dp_wr_r && (dp_addr_r == synlk_pkg::REG_CTRL);
  wire logic wr_unlk = dp_wr_r && (dp_addr_r == synlk_pkg::REG_UNLK_CNT);
  wire logic [31:0] rd_status = {24'h0, 2'(mode), tone, mute, 2'h0, unlock_r};
  wire logic [31:0] rd_count = {3'h0, m_val, 9'h0, p_val};
  wire logic [31:0] rd_mux = !ap_hit ? 32'h0 :
                             (ap_addr == synlk_pkg::REG_CTRL) ? {30'h0, ctrl_r} :
                             (ap_addr == synlk_pkg::REG_STATUS) ? rd_status :
                             (ap_addr == synlk_pkg::REG_COUNT) ? rd_count :
                             (ap_addr == synlk_pkg::REG_UNLK_CNT) ? {16'h0, unlk_cnt_r} :
                             32'h0;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      dp_wr_r <= 1'b0;
      dp_addr_r <= 4'h0;
      hrdata_r <= 32'h0;
    end
    else
    begin
      dp_wr_r <= ap_take && i_hwrite && ap_hit;
      dp_addr_r <= ap_addr;
      if (ap_take && !i_hwrite)
        hrdata_r <= rd_mux;
    end
  end

  // an unlock arriving with the clearing write is still counted
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      ctrl_r <= synlk_pkg::CTRL_RESET;
      unlk_cnt_r <= 16'h0;
      any_unlock_d_r <= 1'b1;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= i_hwdata[1:0];
      unlk_cnt_r <= wr_unlk ? {15'h0, unlock_evt}
                    : (unlock_evt && unlk_cnt_r != 16'hffff) ? unlk_cnt_r + 1'b1 : unlk_cnt_r;
      any_unlock_d_r <= any_unlock;
    end
  end

  // registered outputs
  logic [11:0] out_r;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      out_r <= 12'h020;
    else
      out_r <= {unlock_r, aux_wave, stage_wave[synlk_pkg::REF_IDX_20KHZ],
                main_wave, stage_wave[synlk_pkg::REF_IDX_100HZ],
                mute, tone, stage_wave[synlk_pkg::REF_IDX_1KHZ],
                stage_wave[synlk_pkg::REF_IDX_100KHZ],
                quad_r[0] && !mute, quad_r[1] && !mute};
  end

  assign {o_aux_unlock, o_main_unlock, o_aux_fb, o_aux_ref, o_main_fb, o_main_ref,
          o_mute, o_tone, o_ref_1khz, o_ref_100khz, o_clk14_q, o_clk14_i} = out_r;
  assign o_hrdata = hrdata_r;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_mute_unlock: assert property (any_unlock |=> !o_clk14_i && !o_clk14_q && o_mute)
    else $error("1.4MHz outputs not muted while unlocked");
  a_tone_cause: assert property (o_tone |-> $past(any_unlock))
    else $error("tone without unlock");
  a_swallow_hold: assert property (sw_zero && !sw_load |=> sw_zero)
    else $error("swallow left zero without reload");
  a_swallow_load: assert property (main_tick |=> sw_cnt_r == $past(p_val))
    else $error("swallow not reloaded by main pulse");
  a_swallow_dec: assert property (pre_tick && !sw_load && !sw_zero
                                  |=> sw_cnt_r == $past(sw_cnt_r) - 7'h1)
    else $error("swallow did not count down");
  a_start_101: assert property (main_tick && p_val != 7'h0 |=> pre_mod == 7'h65)
    else $error("cycle did not start at 101");
  a_aux_ratio: assert property (aux_mod == (mode_lsb ? 7'h5c : 7'h55))
    else $error("second divider ratio wrong for mode");
  a_quad_step: assert property ($changed(quad_r) |-> $countones(quad_r ^ $past(quad_r)) == 1)
    else $error("1.4MHz pair not in quadrature");
  a_main_wrap: assert property (main_tick |-> sw_zero)
    else $error("main divider wrapped before swallow reached zero");

  c_main_cycle: cover property (pre_tick ##[1:1000] pre_tick);
  c_main_lock: cover property ($fell(unlock_r[0]));
  c_aux_lock: cover property ($fell(unlock_r[1]));
  c_bus_write: cover property (wr_ctrl);

endmodule

/* tb/synlk_osc_model.sv */
`timescale 1ns/1ps
module synlk_osc_model #(
  parameter int REF_HALF = 2,
  parameter int MAIN_HALF = 3,
  parameter int AUX_HALF = 2
) (
  // system clock, used only to pace the oscillators
  input wire logic i_sys_clk,
  // oscillator pins
  output logic o_reference_oscillator,
  output logic o_main_vco,
  output logic o_aux_vco
);
  int rc;
  int mc;
  int ac;
  // toggling on the falling edge keeps every pin edge clear of the sampling edge
  initial
  begin
    rc = 0;
    mc = 0;
    ac = 0;
    o_reference_oscillator = 1'b0;
    o_main_vco = 1'b0;
    o_aux_vco = 1'b0;
  end
  // each half period spans whole system clocks, so tap periods come out exact
  always @(negedge i_sys_clk)
  begin
    rc <= (rc == REF_HALF - 1) ? 0 : rc + 1;
    mc <= (mc == MAIN_HALF - 1) ? 0 : mc + 1;
    ac <= (ac == AUX_HALF - 1) ? 0 : ac + 1;
    if (rc == REF_HALF - 1) o_reference_oscillator <= ~o_reference_oscillator;
    if (mc == MAIN_HALF - 1) o_main_vco <= ~o_main_vco;
    if (ac == AUX_HALF - 1) o_aux_vco <= ~o_aux_vco;
  end
endmodule

/* tb/test_synth_divider_lock_logic.sv */
`timescale 1ns/1ps
module test_synth_divider_lock_logic;
  // reference and aux vco periods in system clocks, as paced by the model
  localparam int REF_PER = 4;
  localparam int VCO_PER = 4;
  logic sys_clk, rst, hsel, hwrite;
  logic [1:0] htrans, mode, psel;
  logic [31:0] haddr, hwdata, hrdata;
  logic hreadyout, hresp, ref_osc, main_vco, aux_vco;
  logic [3:0] d100, d1k, d10k, d100k, mhz;
  logic clk14_i, clk14_q, ref_100k, ref_1k, tone, mute;
  logic main_fb, main_ref, aux_fb, aux_ref, main_unl, aux_unl;
  logic rd_ph, pv, psig_d;
  logic [31:0] eq[$];
  logic [31:0] mq[$];
  int pq[$];
  int pc, bad_count, n_compared;
  wire psig = psel == 2'h0 ? ref_100k : psel == 2'h1 ? aux_ref : aux_fb;

  synlk_osc_model synlk_osc_model_i (.i_sys_clk(sys_clk), .o_reference_oscillator(ref_osc),
    .o_main_vco(main_vco), .o_aux_vco(aux_vco));

  synlk_top synlk_top_i (.i_sys_clk(sys_clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
    .i_reference_oscillator(ref_osc), .i_main_vco(main_vco), .i_aux_vco(aux_vco),
    .i_sw_100hz(d100), .i_sw_1khz(d1k), .i_sw_10khz(d10k), .i_sw_100khz(d100k),
    .i_sw_1mhz(mhz), .i_mode(mode), .o_clk14_i(clk14_i), .o_clk14_q(clk14_q),
    .o_ref_100khz(ref_100k), .o_ref_1khz(ref_1k), .o_tone(tone), .o_mute(mute),
    .o_main_fb(main_fb), .o_main_ref(main_ref), .o_aux_fb(aux_fb), .o_aux_ref(aux_ref),
    .o_main_unlock(main_unl), .o_aux_unlock(aux_unl));

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one single transfer; a read notes its expected word and mask before the address phase
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    if (!w)
    begin
      eq.push_back(d);
      mq.push_back(m);
    end
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'b00;
    hwdata <= w ? d : $urandom;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
  endtask

  // read data is taken at the edge that ends the data phase
  always @(posedge sys_clk)
  begin
    rd_ph <= hsel && htrans == 2'b10 && !hwrite && hreadyout;
    if (rd_ph && eq.size() > 0) check(hrdata & mq.pop_front(), eq.pop_front());
  end

  // period monitor: the first rise after a note arms it, the next rise is compared
  always @(posedge sys_clk)
  begin
    psig_d <= psig;
    pc <= pc + 1;
    if (psig && !psig_d)
    begin
      pc <= 1;
      if (pv && pq.size() > 0) check(pc, pq.pop_front());
      pv <= pq.size() > 0;
    end
  end

  task automatic measure(input logic [1:0] s, input int e);
    @(posedge sys_clk);
    psel <= s;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    pq.push_back(e);
    for (int k = 0; k < 20000 && pq.size() > 0; k++) @(posedge sys_clk);
    check(32'(pq.size()), 32'h0);
  endtask

  initial
  begin
    repeat (98000) @(posedge sys_clk);
    bad_count++;
    results();
  end

  initial
  begin
    logic [1:0] modes [3];
    int ratio [3];
    int p;
    int m;
    modes = '{synlk_pkg::SYNLK_MODE_USB, synlk_pkg::SYNLK_MODE_LSB, synlk_pkg::SYNLK_MODE_AM};
    ratio = '{85, 92, 85};
    bad_count = 0;
    n_compared = 0;
    pc = 0;
    pv = 1'b0;
    psig_d = 1'b0;
    rd_ph = 1'b0;
    rst = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    psel = 2'h0;
    mode = synlk_pkg::SYNLK_MODE_USB;
    void'($urandom(39706));
    {d100, d1k, d10k, d100k, mhz} = '0;
    repeat (20) @(posedge sys_clk);
    check({hreadyout, hresp, mute}, 32'h5);
    rst <= 1'b0;
    // ctrl resets to tone enabled, takes a write, unmapped space stays empty
    bus(1'b0, 32'h0, 32'h1, 32'hffffffff);
    bus(1'b1, 32'h0, 32'h2, 32'h0);
    // tone disabled: stays silent although unlocked
    repeat (2) @(negedge sys_clk);
    check(tone, 32'h0);
    bus(1'b0, 32'h0, 32'h2, 32'hffffffff);
    bus(1'b1, 32'h0, 32'h1, 32'h0);
    // both slow taps start in their high half, so the unlock tone sounds
    repeat (2) @(negedge sys_clk);
    check(tone, 32'h1);
    bus(1'b1, 32'h10, 32'hffffffff, 32'h0);
    bus(1'b0, 32'h10, 32'h0, 32'hffffffff);
    bus(1'b1, 32'hc, 32'h0, 32'h0);
    bus(1'b0, 32'hc, 32'h0, 32'hffff);
    // division counts follow the panel digits
    repeat (3)
    begin
      @(posedge sys_clk);
      d100 <= 4'($urandom % 10);
      d1k <= 4'($urandom % 10);
      d10k <= 4'($urandom % 10);
      d100k <= 4'($urandom % 10);
      mhz <= 4'($urandom % 16);
      repeat (10) @(posedge sys_clk);
      p = 10 * d1k + d100;
      m = 3540 + 100 * mhz + 10 * d100k + d10k;
      bus(1'b0, 32'h8, 32'((m << 16) | p), 32'h1fff007f);
    end
    // reference taps: divide-by-four, then a modulo-seven first stage
    measure(2'h0, 4 * 7 * 2 * REF_PER);
    measure(2'h1, 4 * 7 * 2 * 5 * REF_PER);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge sys_clk);
      mode <= modes[i];
      // a mode change mid-count leaves one odd period; let it pass
      if (i > 0) repeat (11000) @(posedge sys_clk);
      bus(1'b0, 32'h4, 32'(modes[i]) << 6 | 32'h11, 32'hd1);
      check({main_unl, mute, clk14_i, clk14_q}, 32'hc);
      measure(2'h2, 20 * ratio[i] * VCO_PER);
    end
    results();
  end
endmodule
